// ---- common/sfm_params.svh ----
// Frame geometry, slot mapping and fill constants for the frame slot mapper
`ifndef SFM_PARAMS_SVH
`define SFM_PARAMS_SVH

`define SFM_N_DEF        1
`define SFM_ROWS         9
`define SFM_COLS_BASE    270
`define SFM_SOH_COLS     9
`define SFM_PTR_ROW      4
`define SFM_OPT_ROW      1
`define SFM_RS_LAST_ROW  3
`define SFM_BITS_BYTE    8
`define SFM_TU12_FIRST   10
`define SFM_TU12_SLOTS   63
`define SFM_TU2_FIRST    10
`define SFM_TU2_SLOTS    21
`define SFM_TU3_FIRST    4
`define SFM_TU3_SLOTS    3
`define SFM_FIFO_DEPTH   4
`define SFM_DEF_BYTE     8'h00
`define SFM_RSV_MASK     9'h1c0
`define SFM_FILL_OPT     0
`define SFM_FILL_RS      1
`define SFM_FILL_MS      2

`endif

// ---- common/sfm_pkg.sv ----
// Types shared by the frame slot mapper modules
`default_nettype none

package sfm_pkg;

    // Payload configuration that selects the time-slot pattern
    typedef enum logic [1:0] {
        SFM_MODE_TU12 = 2'b00,
        SFM_MODE_TU2  = 2'b01,
        SFM_MODE_TU3  = 2'b10,
        SFM_MODE_NONE = 2'b11
    } sfm_mode_t;

    // Owner of a byte position in the frame
    typedef enum logic [2:0] {
        SFM_LAYER_PAYLOAD = 3'b000,
        SFM_LAYER_OPT     = 3'b001,
        SFM_LAYER_RS      = 3'b010,
        SFM_LAYER_MS      = 3'b011,
        SFM_LAYER_PTR     = 3'b100
    } sfm_layer_t;

endpackage : sfm_pkg

`default_nettype wire

// ---- hw/sfm_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`default_nettype none
`include "sfm_params.svh"

module sfm_fifo #(
    parameter int W = 8,
    parameter int D = `SFM_FIFO_DEPTH
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_nrst,
    input  wire logic         i_vld,
    output logic              o_rdy,
    input  wire logic [W-1:0] i_data,
    output logic              o_vld,
    input  wire logic         i_rdy,
    output logic [W-1:0]      o_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic          push;
    logic          pop;

    // Full and empty come straight from the occupancy count
    assign o_rdy  = (count != CW'(D));
    assign o_vld  = (count != '0);
    assign o_data = mem[rd_ptr];
    assign push   = i_vld && o_rdy;
    assign pop    = o_vld && i_rdy;

    // Storage needs no reset; only words under the count are read
    always_ff @(posedge i_clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr] <= i_data;
        end
    end

    // Pointers wrap at depth, which need not be a power of two
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end

endmodule : sfm_fifo

`default_nettype wire

// ---- hw/sfm_slot_map.sv ----
// Maps a VC-4 column to a time slot and a tributary address
`default_nettype none
`include "sfm_params.svh"

module sfm_slot_map (
    input  wire logic             i_payload,
    input  wire logic [8:0]       i_vc_col,
    input  wire sfm_pkg::sfm_mode_t i_mode,
    output logic [5:0]            o_ts,
    output logic                  o_ts_vld,
    output logic [1:0]            o_k,
    output logic [2:0]            o_l,
    output logic [1:0]            o_m
);
    // Zero-based slot index of a column in a repeating pattern
    function automatic logic [5:0] slot_idx(input logic [8:0] col,
                                            input int first,
                                            input int slots);
        int d;
        d = int'(col) - first;
        return 6'(d % slots);
    endfunction : slot_idx

    logic [5:0] idx;

    // Slot numbering depends only on mode and column; port numbers live elsewhere
    always_comb
    begin
        idx      = '0;
        o_ts     = '0;
        o_ts_vld = 1'b0;
        o_k      = '0;
        o_l      = '0;
        o_m      = '0;
        case (i_mode)
            sfm_pkg::SFM_MODE_TU12:
            begin
                if (i_payload && i_vc_col >= 9'(`SFM_TU12_FIRST))
                begin
                    idx      = slot_idx(i_vc_col, `SFM_TU12_FIRST,
                                        `SFM_TU12_SLOTS);
                    o_ts     = idx + 6'h01;
                    o_ts_vld = 1'b1;
                    o_k      = 2'(idx % 6'h03) + 2'h1;
                    o_l      = 3'((idx / 6'h03) % 6'h07) + 3'h1;
                    o_m      = 2'(idx / 6'h15) + 2'h1;
                end
            end
            sfm_pkg::SFM_MODE_TU2:
            begin
                if (i_payload && i_vc_col >= 9'(`SFM_TU2_FIRST))
                begin
                    idx      = slot_idx(i_vc_col, `SFM_TU2_FIRST,
                                        `SFM_TU2_SLOTS);
                    o_ts     = idx + 6'h01;
                    o_ts_vld = 1'b1;
                    o_k      = 2'(idx % 6'h03) + 2'h1;
                    o_l      = 3'(idx / 6'h03) + 3'h1;
                end
            end
            sfm_pkg::SFM_MODE_TU3:
            begin
                if (i_payload && i_vc_col >= 9'(`SFM_TU3_FIRST))
                begin
                    idx      = slot_idx(i_vc_col, `SFM_TU3_FIRST,
                                        `SFM_TU3_SLOTS);
                    o_ts     = idx + 6'h01;
                    o_ts_vld = 1'b1;
                    o_k      = 2'(idx) + 2'h1;
                end
            end
            default:
            begin
                o_ts_vld = 1'b0;
            end
        endcase
    end

endmodule : sfm_slot_map

`default_nettype wire

// ---- hw/sfm_frame_mapper.sv ----
// Frame position tracker, overhead fill and time-slot tagger (top level)
//
// What this block does
// - Bit 1 of each byte is the MSB and arrives first; bit 8 last.
// - Reserved overhead rows: 1 optical, 2-3 regenerator, 5-9 multiplex.
// - Each layer's reserved overhead bytes are forced to their default value.
// - Overhead bytes are located by row 1..9 and column 1..9N.
// - Three-index form: row=a, column=N(b-1)+c.
// - A row has 270N columns; first 9N overhead and pointer, 261N payload.
// - Payload columns carry a TUG-3, TUG-2, TU-1 address.
// - TU-12 slots run 1..63 over VC-4 columns 10..72.
// - TU-3 slots 1, 2, 3 start at VC-4 columns 4, 5, 6.
// - Time-slot index is never used as the tributary port number.
`default_nettype none
`include "sfm_params.svh"

module sfm_frame_mapper #(
    parameter int            N        = `SFM_N_DEF,
    parameter int            COLW     = 12,
    parameter int            DEPTH    = `SFM_FIFO_DEPTH,
    parameter logic [8:0]    RSV_MASK = `SFM_RSV_MASK,
    parameter logic [7:0]    DEF_BYTE = `SFM_DEF_BYTE
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_nrst,
    input  wire logic                 i_bit,
    input  wire logic                 i_bit_vld,
    input  wire logic                 i_frame_start,
    input  wire sfm_pkg::sfm_mode_t   i_ts_mode,
    input  wire logic [2:0]           i_fill_en,
    input  wire logic                 i_out_rdy,
    output logic                      o_vld,
    output logic [7:0]                o_byte,
    output logic [3:0]                o_row,
    output logic [COLW-1:0]           o_col,
    output var sfm_pkg::sfm_layer_t   o_layer,
    output logic                      o_rsv,
    output logic [3:0]                o_soh_b,
    output logic [3:0]                o_soh_c,
    output logic [5:0]                o_ts,
    output logic                      o_ts_vld,
    output logic [1:0]                o_k,
    output logic [2:0]                o_l,
    output logic [1:0]                o_m,
    output logic                      o_in_rdy,
    output logic                      o_ovf
);
    localparam int COLS = `SFM_COLS_BASE * N;
    localparam int OVH  = `SFM_SOH_COLS * N;
    localparam int WW   = 38 + COLW;

    logic [6:0]          shreg;
    logic [2:0]          bcnt;
    logic                locked;
    logic [3:0]          row;
    logic [COLW-1:0]     col;
    logic                byte_done;
    logic [7:0]          next_byte;
    logic                ovh;
    logic [3:0]          soh_b;
    logic [3:0]          soh_c;
    logic [8:0]          vc_col;
    sfm_pkg::sfm_layer_t layer;
    logic                rsv;
    logic                fill;
    logic [5:0]          ts;
    logic                ts_vld;
    logic [1:0]          tk;
    logic [2:0]          tl;
    logic [1:0]          tm;
    logic                st_vld;
    logic [WW-1:0]       st_word;
    logic                f_irdy;
    logic                f_ovld;
    logic [WW-1:0]       f_data;
    logic                take;
    logic                drop;

    // Serial bits shift in at the right end and move left, so the first bit is the MSB
    assign byte_done = i_bit_vld && !i_frame_start && (bcnt == 3'h7);
    assign next_byte = {shreg, i_bit};

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            shreg <= '0;
            bcnt  <= '0;
        end
        else if (i_bit_vld)
        begin
            // Frame start realigns the byte boundary on its own bit
            if (i_frame_start)
            begin
                shreg <= {6'h00, i_bit};
                bcnt  <= 3'h1;
            end
            else
            begin
                shreg <= next_byte[6:0];
                bcnt  <= bcnt + 3'h1;
            end
        end
    end

    // Position counters name the byte now being assembled
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            row    <= 4'h1;
            col    <= COLW'(1);
            locked <= 1'b0;
        end
        else if (i_bit_vld && i_frame_start)
        begin
            row    <= 4'h1;
            col    <= COLW'(1);
            locked <= 1'b1;
        end
        else if (byte_done)
        begin
            if (col == COLW'(COLS))
            begin
                col <= COLW'(1);
                row <= (row == 4'(`SFM_ROWS)) ? 4'h1 : row + 4'h1;
            end
            else
            begin
                col <= col + COLW'(1);
            end
        end
    end

    // Overhead lives in the first nine columns per multiple of the rate
    always_comb
    begin
        ovh    = (col <= COLW'(OVH));
        soh_b  = 4'((int'(col) - 1) / N + 1);
        soh_c  = 4'((int'(col) - 1) % N + 1);
        vc_col = ovh ? 9'h000 : 9'((int'(col) - OVH - 1) / N + 1);
        if (!ovh)
            layer = sfm_pkg::SFM_LAYER_PAYLOAD;
        else if (row == 4'(`SFM_PTR_ROW))
            layer = sfm_pkg::SFM_LAYER_PTR;
        else if (row == 4'(`SFM_OPT_ROW))
            layer = sfm_pkg::SFM_LAYER_OPT;
        else if (row <= 4'(`SFM_RS_LAST_ROW))
            layer = sfm_pkg::SFM_LAYER_RS;
        else
            layer = sfm_pkg::SFM_LAYER_MS;
        rsv = ovh && (layer != sfm_pkg::SFM_LAYER_PTR) &&
              RSV_MASK[soh_b - 4'h1];
        case (layer)
            sfm_pkg::SFM_LAYER_OPT: fill = rsv && i_fill_en[`SFM_FILL_OPT];
            sfm_pkg::SFM_LAYER_RS:  fill = rsv && i_fill_en[`SFM_FILL_RS];
            sfm_pkg::SFM_LAYER_MS:  fill = rsv && i_fill_en[`SFM_FILL_MS];
            default:                fill = 1'b0;
        endcase
    end

    // Column-to-slot lookup; the result is a slot, not a port number
    sfm_slot_map u_slot (
        .i_payload (!ovh),
        .i_vc_col  (vc_col),
        .i_mode    (i_ts_mode),
        .o_ts      (ts),
        .o_ts_vld  (ts_vld),
        .o_k       (tk),
        .o_l       (tl),
        .o_m       (tm)
    );

    // One staging word; bytes come at most every eight cycles so it drains
    assign take = byte_done && locked && !(st_vld && !f_irdy);
    assign drop = byte_done && locked && st_vld && !f_irdy;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_vld  <= 1'b0;
            st_word <= '0;
        end
        else
        begin
            if (take)
            begin
                st_vld  <= 1'b1;
                st_word <= {fill ? DEF_BYTE : next_byte,
                            row, col, layer, rsv, soh_b, soh_c,
                            ts, ts_vld, tk, tl, tm};
            end
            else if (f_irdy)
            begin
                st_vld <= 1'b0;
            end
        end
    end

    sfm_fifo #(
        .W (WW),
        .D (DEPTH)
    ) u_fifo (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_vld     (st_vld),
        .o_rdy     (f_irdy),
        .i_data    (st_word),
        .o_vld     (f_ovld),
        .i_rdy     (!o_vld || i_out_rdy),
        .o_data    (f_data)
    );

    // Output register keeps every port on a flop while honouring stalls
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_vld    <= 1'b0;
            o_byte   <= '0;
            o_row    <= '0;
            o_col    <= '0;
            o_layer  <= sfm_pkg::SFM_LAYER_PAYLOAD;
            o_rsv    <= 1'b0;
            o_soh_b  <= '0;
            o_soh_c  <= '0;
            o_ts     <= '0;
            o_ts_vld <= 1'b0;
            o_k      <= '0;
            o_l      <= '0;
            o_m      <= '0;
        end
        else if (!o_vld || i_out_rdy)
        begin
            o_vld <= f_ovld;
            // Fields unpacked one by one so the layer enum gets a cast
            if (f_ovld)
            begin
                o_byte   <= f_data[WW-1 -: 8];
                o_row    <= f_data[WW-9 -: 4];
                o_col    <= f_data[WW-13 -: COLW];
                o_layer  <= sfm_pkg::sfm_layer_t'(f_data[25:23]);
                o_rsv    <= f_data[22];
                o_soh_b  <= f_data[21:18];
                o_soh_c  <= f_data[17:14];
                o_ts     <= f_data[13:8];
                o_ts_vld <= f_data[7];
                o_k      <= f_data[6:5];
                o_l      <= f_data[4:2];
                o_m      <= f_data[1:0];
            end
        end
    end

    // Lost bytes are flagged until the next frame start; a loss wins
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_ovf    <= 1'b0;
            o_in_rdy <= 1'b0;
        end
        else
        begin
            o_in_rdy <= f_irdy;
            if (drop)
                o_ovf <= 1'b1;
            else if (i_bit_vld && i_frame_start)
                o_ovf <= 1'b0;
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    sequence s_last_col;
        byte_done && col == COLW'(COLS);
    endsequence

    col_wrap_a: assert property (
        (s_last_col and !i_frame_start) |=> col == COLW'(1))
        else $error("column did not wrap to 1 after the last column");

    row_step_a: assert property (
        (s_last_col and row != 4'(`SFM_ROWS))
        |=> row == $past(row) + 4'h1)
        else $error("row did not advance on column wrap");

    fs_restart_a: assert property (
        i_bit_vld && i_frame_start |=> row == 4'h1 && col == COLW'(1)
        && bcnt == 3'h1)
        else $error("frame start did not restart the counters");

    // Older bits must move toward the MSB end as each new bit arrives
    msb_first_a: assert property (
        i_bit_vld && !i_frame_start
        |=> shreg == 7'({$past(shreg), $past(i_bit)}))
        else $error("serial bits not shifted toward the MSB end");

    layer_row_a: assert property (
        take && layer == sfm_pkg::SFM_LAYER_RS
        |-> row >= 4'h2 && row <= 4'(`SFM_RS_LAST_ROW) && ovh)
        else $error("regenerator layer outside rows 2 and 3");

    fill_def_a: assert property (
        take && fill |=> st_word[WW-1 -: 8] == DEF_BYTE)
        else $error("reserved byte not set to its default");

    soh_index_a: assert property (
        ovh |-> int'(col) == N * (int'(soh_b) - 1) + int'(soh_c)
        && soh_b <= 4'(`SFM_SOH_COLS))
        else $error("three-index form disagrees with the column");

    tu12_slot_a: assert property (
        i_ts_mode == sfm_pkg::SFM_MODE_TU12 && !ovh
        |-> ((vc_col == 9'h00a) -> ts == 6'h01)
        && ((vc_col == 9'h048) -> ts == 6'h3f)
        && ((vc_col < 9'h00a) -> !ts_vld))
        else $error("TU-12 slot numbering wrong");

    tu2_slot_a: assert property (
        i_ts_mode == sfm_pkg::SFM_MODE_TU2 && !ovh
        |-> ((vc_col == 9'h00a) -> ts == 6'h01)
        && ((vc_col == 9'h01e) -> ts == 6'h15))
        else $error("TU-2 slot numbering wrong");

    tu3_slot_a: assert property (
        i_ts_mode == sfm_pkg::SFM_MODE_TU3 && !ovh && vc_col >= 9'h004
        && vc_col <= 9'h006 |-> ts == 6'(vc_col - 9'h003) && ts_vld)
        else $error("TU-3 slot numbering wrong");

endmodule : sfm_frame_mapper

`default_nettype wire

// ---- verification/sfm_line_src.sv ----
// Line-side framer model: serial bit source with frame start marker
`default_nettype none

module sfm_line_src (
    input  wire logic i_clk_sys,
    output logic      o_bit,
    output logic      o_bit_vld,
    output logic      o_frame_start
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle until the bench asks for traffic
    initial
    begin
        o_bit = 1'b0;
        o_bit_vld = 1'b0;
        o_frame_start = 1'b0;
    end

    // Sends the top n bits of v, MSB first, back to back with the previous
    task automatic send(input logic [7:0] v, input int n, input logic fs);
        for (int i = 0; i < n; i++)
        begin
            @(negedge i_clk_sys);
            o_bit = v[7 - i];
            o_bit_vld = 1'b1;
            o_frame_start = fs && (i == 0);
        end
    endtask : send

    // Drops valid; the data line flips so a stale bit never looks valid
    task automatic idle;
        @(negedge i_clk_sys);
        o_bit_vld = 1'b0;
        o_frame_start = 1'b0;
        o_bit = ~o_bit;
    endtask : idle
endmodule : sfm_line_src

`default_nettype wire

// ---- verification/sfm_frame_mapper_tb.sv ----
// Self-checking bench for the frame slot mapper
`default_nettype none
`include "sfm_params.svh"

module sfm_frame_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk_sys = 1'b0;
    logic               nrst = 1'b0;
    logic               bit_d, bit_vld, fstart, vld, rsv, ts_vld, in_rdy;
    logic               ovf;
    logic               out_rdy = 1'b0;
    logic [1:0]         rdy_mode = 2'h0;
    logic               chk_on = 1'b1;
    sfm_pkg::sfm_mode_t mode = sfm_pkg::SFM_MODE_TU12;
    sfm_pkg::sfm_layer_t layer;
    logic [2:0]         fill_en = 3'h5;
    logic [7:0]         byte_o;
    logic [3:0]         row, soh_b, soh_c;
    logic [11:0]        col;
    logic [5:0]         ts;
    logic [1:0]         k, m;
    logic [2:0]         l;
    logic [25:0]        expq[$];
    int                 n_errors = 0;
    int                 samples_checked = 0;

    always #2.5 clk_sys = ~clk_sys;

    sfm_line_src src (.i_clk_sys(clk_sys), .o_bit(bit_d),
                      .o_bit_vld(bit_vld), .o_frame_start(fstart));

    sfm_frame_mapper uut (
        .i_clk_sys(clk_sys), .i_nrst(nrst), .i_bit(bit_d),
        .i_bit_vld(bit_vld), .i_frame_start(fstart), .i_ts_mode(mode),
        .i_fill_en(fill_en), .i_out_rdy(out_rdy), .o_vld(vld),
        .o_byte(byte_o), .o_row(row), .o_col(col), .o_layer(layer),
        .o_rsv(rsv), .o_soh_b(soh_b), .o_soh_c(soh_c), .o_ts(ts),
        .o_ts_vld(ts_vld), .o_k(k), .o_l(l), .o_m(m),
        .o_in_rdy(in_rdy), .o_ovf(ovf));

    // Downstream sink: 0 stalls, 1 always takes, 2 takes every other cycle
    always @(negedge clk_sys)
        out_rdy <= (rdy_mode == 2'h2) ? ~out_rdy : rdy_mode[0];

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, want);
        end
    endtask : check

    // Works out the fields of a word from its mode, row, column and data; soh_b and soh_c only as a sum, on overhead
    task automatic judge(input logic [25:0] e);
        int md = e[25:24];
        int r = e[23:20];
        int c = e[19:8];
        int fst = (md == 2) ? 4 : 10;
        int per = (md == 0) ? 63 : (md == 1) ? 21 : 3;
        int ix = (c - 9 - fst) % per;
        logic oh = (c <= 9);
        logic rv = oh && c >= 7 && r != 4;
        logic [2:0] ly = !oh ? 3'h0 : r == 1 ? 3'h1 : r <= 3 ? 3'h2 :
                         r == 4 ? 3'h4 : 3'h3;
        logic [7:0] d = (rv && fill_en[ly - 3'h1]) ? `SFM_DEF_BYTE : e[7:0];
        check(16'(row), 16'(r));
        check(16'(col), 16'(c));
        check(16'(byte_o), 16'(d));
        check(16'(rsv), 16'(rv));
        check(16'(layer), 16'(ly));
        if (oh)
            check(16'(soh_b - 4'h1 + soh_c), 16'(c));
        if (md != 3 && c - 9 >= fst)
        begin
            check(16'({ts_vld, ts}), 16'(ix + 65));
            check(16'(k), 16'(md == 2 ? ix + 1 : ix % 3 + 1));
            check(16'(l), 16'(md == 0 ? (ix / 3) % 7 + 1 :
                              md == 1 ? ix / 3 + 1 : 0));
            check(16'(m), 16'(md == 0 ? ix / 21 + 1 : 0));
        end
        else
            check(16'(ts_vld), 16'h0);
    endtask : judge

    // Scoreboard: design outputs are flops, so this sees pre-edge values
    always @(posedge clk_sys)
    begin
        if (nrst && chk_on && vld === 1'b1 && out_rdy)
        begin
            if (expq.size() == 0)
                check(16'(vld), 16'h0);
            else
                judge(expq.pop_front());
        end
    end

    // Sends nb bytes from a frame start, queueing the expected words
    task automatic send_frame(input logic [1:0] md, input int nb);
        int r = 1;
        int c = 1;
        for (int i = 0; i < nb; i++)
        begin
            expq.push_back({md, 4'(r), 12'(c), 8'(i * 37 + 5)});
            src.send(8'(i * 37 + 5), 8, i == 0);
            c++;
            if (c > 270)
            begin
                c = 1;
                r = (r == 9) ? 1 : r + 1;
            end
        end
        src.idle();
    endtask : send_frame

    task automatic drain;
        for (int i = 0; i < 400 && expq.size() != 0; i++)
            @(posedge clk_sys);
        repeat (4) @(negedge clk_sys);
        check(16'(expq.size()), 16'h0);
    endtask : drain

    // Reset levels, then bits with no frame start must give no output
    task automatic sc_reset;
        @(negedge clk_sys);
        check(16'({vld, ovf, in_rdy}), 16'h1);
        src.send(8'ha5, 8, 1'b0);
        src.send(8'h3c, 8, 1'b0);
        src.idle();
        repeat (30) @(negedge clk_sys);
        check(16'(vld), 16'h0);
    endtask : sc_reset

    // A full frame plus one byte shows the row wrap back to row 1
    task automatic sc_full_tu12;
        rdy_mode = 2'h2;
        send_frame(2'h0, 2431);
        drain();
    endtask : sc_full_tu12

    // Each other mode after a partial byte that a frame start must discard
    task automatic sc_modes;
        for (int md = 1; md < 4; md++)
        begin
            mode = sfm_pkg::sfm_mode_t'(md);
            fill_en = 3'(md * 3);
            src.send(8'hff, 3, 1'b0);
            send_frame(2'(md), 280);
            drain();
        end
    endtask : sc_modes

    // Stalled sink fills the buffer until bytes drop, then recovery
    task automatic sc_overflow;
        rdy_mode = 2'h0;
        chk_on = 1'b0;
        src.send(8'h11, 8, 1'b1);
        for (int i = 0; i < 9; i++)
            src.send(8'(i), 8, 1'b0);
        src.idle();
        @(negedge clk_sys);
        check(16'({in_rdy, ovf}), 16'h1);
        rdy_mode = 2'h1;
        repeat (40) @(negedge clk_sys);
        check(16'({vld, ovf}), 16'h1);
        chk_on = 1'b1;
        mode = sfm_pkg::SFM_MODE_TU12;
        send_frame(2'h0, 4);
        drain();
        check(16'(ovf), 16'h0);
    endtask : sc_overflow

    task automatic report_and_stop;
        $display("checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        sc_reset();
        sc_full_tu12();
        sc_modes();
        sc_overflow();
        report_and_stop();
    end

    // Watchdog: the whole run needs about 30000 cycles
    initial
    begin
        repeat (80000) @(posedge clk_sys);
        n_errors++;
        report_and_stop();
    end
endmodule : sfm_frame_mapper_tb

`default_nettype wire
